// *** design/pmlrt_buf.sv ***
`timescale 1ns/100ps
// Shift-down buffer; every output comes from a flip-flop.
module pmlrt_buf #(
	parameter int W = 4,
	parameter int DEPTH = 2
) (
	// Clock, reset and enable.
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// Filling side.
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Draining side.
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] mem_d [DEPTH];
	logic [DEPTH-1:0] vld_q, vld_d;

	// Pop shifts the entries down; a push fills the lowest free slot.
	always_comb begin
		logic put;
		put = in_valid_i & ~vld_q[DEPTH-1];
		mem_d = mem_q;
		vld_d = vld_q;
		if (vld_q[0] & out_ready_i) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				mem_d[i] = mem_q[i+1];
				vld_d[i] = vld_q[i+1];
			end
			vld_d[DEPTH-1] = 1'b0;
		end
		for (int i = 0; i < DEPTH; i++) begin
			if (put && !vld_d[i]) begin
				mem_d[i] = in_data_i;
				vld_d[i] = 1'b1;
				put = 1'b0;
			end
		end
	end

	// Storage registers.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			vld_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (ce_i) begin
			vld_q <= vld_d;
			mem_q <= mem_d;
		end
	end

	assign in_ready_o = ~vld_q[DEPTH-1];
	assign out_valid_o = vld_q[0];
	assign out_data_o = mem_q[0];
endmodule : pmlrt_buf

// *** design/pmlrt_phy_timing.sv ***
`timescale 1ns/100ps
module pmlrt_phy_timing
	import pmlrt_pkg::*;
#(
	parameter int unsigned JAB_ON_CYC = JAB_ON_CYC_DEF,
	parameter int unsigned JAB_OFF_CYC = JAB_OFF_CYC_DEF,
	parameter int unsigned POR_CYC = POR_CYC_DEF,
	parameter int unsigned HWR_CYC = HWR_CYC_DEF
) (
	// System clock, reset and enable.
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// Recovered line clock.
	input wire logic clk_line_i,
	// Mode straps and reset pin.
	input wire pmlrt_mode_t mode_i,
	input wire logic hw_reset_low_in_i,
	// MAC transmit and receive.
	input wire pmlrt_sym_t mac_tx_i,
	output pmlrt_sym_t mac_rx_o,
	input wire logic mac_rx_ready_i,
	output logic crs_o,
	output logic col_o,
	output logic tx_clk_ok_o,
	// Line transmit and receive.
	output pmlrt_sym_t line_transmit_pair_o,
	input wire pmlrt_line_rx_t line_receive_pair_i,
	output logic line_rx_ready_o
);
	// Line domain state.
	logic l_req_q, l_req_d, l_j_q, l_j_d, l_t_q, l_t_d;
	logic l_ack1_q, l_ack1_d, l_ack2_q, l_ack2_d, l_rdy_q, l_rdy_d;
	logic [3:0] l_word_q, l_word_d;
	// Control state.
	logic [3:0] s1_q, s1_d, s2_q, s2_d;
	logic [1:0] s3_q, s3_d, iso_cnt_q, iso_cnt_d;
	pmlrt_init_t init_q, init_d;
	logic [23:0] init_cnt_q, init_cnt_d;
	logic clk_ok_q, clk_ok_d;
	// Transmit state.
	pmlrt_sym_t [TX_PIPE-1:0] pipe_q, pipe_d;
	pmlrt_sym_t line_q, line_d;
	pmlrt_jab_t jab_q, jab_d;
	logic [23:0] jab_cnt_q, jab_cnt_d;
	logic [6:0] hb_cnt_q, hb_cnt_d;
	logic [4:0] hold_q, hold_d;
	logic crs_tx, hb_col;
	// Receive state.
	logic ack_q, ack_d, crs_rx_q, crs_rx_d, col_rx_q, col_rx_d, col_pend_q, col_pend_d;
	logic open_q, open_d, crs_q, crs_d, col_q, col_d;
	logic [2:0] on_q, on_d, off_q, off_d, gate_q, gate_d;
	logic run, hw_n, j_ev, t_ev, half10, push, buf_rdy, buf_vld;
	logic [3:0] buf_dat;

	// Picks the transmit nibble as it stood one cycle fewer than the given count ago; a count of one or less picks the current one.
	function automatic pmlrt_sym_t tap(input pmlrt_sym_t [TX_PIPE-1:0] p,
			input pmlrt_sym_t cur, input int unsigned l);
		return (l <= 1) ? cur : p[l-2];
	endfunction : tap

	// Line side: take a nibble while ready; ready reads only the second acknowledge flop.
	always_comb begin
		l_ack1_d = ack_q;
		l_ack2_d = l_ack1_q;
		l_req_d = l_req_q;
		l_word_d = l_word_q;
		if (line_receive_pair_i.valid && l_rdy_q) begin
			l_word_d = line_receive_pair_i.sym;
			l_req_d = ~l_req_q;
		end
		l_rdy_d = (l_req_d == l_ack2_q);
		l_j_d = l_j_q ^ line_receive_pair_i.j;
		l_t_d = l_t_q ^ line_receive_pair_i.t;
	end

	// Line side registers.
	always_ff @(posedge clk_line_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{l_req_q, l_j_q, l_t_q, l_ack1_q, l_ack2_q} <= '0;
			l_rdy_q <= 1'b1;
			l_word_q <= '0;
		end else begin
			{l_req_q, l_j_q, l_t_q, l_ack1_q, l_ack2_q} <= {l_req_d, l_j_d, l_t_d, l_ack1_d, l_ack2_d};
			l_rdy_q <= l_rdy_d;
			l_word_q <= l_word_d;
		end
	end

	assign run = (init_q == INIT_RUN);
	assign hw_n = s2_q[3];
	assign j_ev = s2_q[2] ^ s3_q[1];
	assign t_ev = s2_q[1] ^ s3_q[0];
	assign half10 = mode_i.half & ~mode_i.spd100;

	// Synchronisers and the initialization sequence.
	always_comb begin
		s1_d = {hw_reset_low_in_i, l_j_q, l_t_q, l_req_q};
		s2_d = s1_q;
		s3_d = s2_q[2:1];
		init_d = init_q;
		init_cnt_d = init_cnt_q;
		iso_cnt_d = '0;
		case (init_q)
			INIT_WAIT: begin
				if (init_cnt_q <= 24'h000001) begin
					init_d = INIT_RUN;
				end else begin
					init_cnt_d = init_cnt_q - 24'h000001;
				end
			end
			INIT_ISO: begin
				if (hw_n) begin
					init_d = INIT_WAIT;
					init_cnt_d = 24'(HWR_CYC);
				end
			end
			INIT_RUN: init_d = INIT_RUN;
			default: init_d = INIT_ISO;
		endcase
		// The pin must stay low for the isolation delay before the block goes quiet.
		if (!hw_n && init_q != INIT_ISO) begin
			iso_cnt_d = iso_cnt_q + 2'h1;
			if (iso_cnt_q == 2'(ISO_CYC - 1)) begin
				init_d = INIT_ISO;
			end
		end
		clk_ok_d = (init_d == INIT_RUN);
	end

	// Control registers; the power-on count loads at reset.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_q <= SYNC_RST;
			s2_q <= SYNC_RST;
			s3_q <= '0;
			iso_cnt_q <= '0;
			init_q <= INIT_WAIT;
			init_cnt_q <= 24'(POR_CYC);
			clk_ok_q <= 1'b0;
		end else if (ce_i) begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			iso_cnt_q <= iso_cnt_d;
			init_q <= init_d;
			init_cnt_q <= init_cnt_d;
			clk_ok_q <= clk_ok_d;
		end
	end

	// Transmit delay line, carrier from transmit, heartbeat and jabber.
	always_comb begin
		pmlrt_sym_t sel;
		logic on;
		on = 1'b0;
		sel = mode_i.stream ? tap(pipe_q, mac_tx_i, TXJ_STR_CYC) :
			tap(pipe_q, mac_tx_i, mode_i.spd100 ? TXJ_MII100_CYC : TXJ_MII10_CYC);
		pipe_d = {pipe_q[TX_PIPE-2:0], mac_tx_i};
		line_d = sel;
		line_d.en = sel.en & run & (jab_q == JAB_IDLE);
		// Carrier rises after the on delay; in 10M only it is stretched to the off delay.
		on = tap(pipe_q, mac_tx_i, mode_i.spd100 ? CRS_TX100_CYC : CRS_ON10_CYC).en;
		if (on) begin
			hold_d = mode_i.spd100 ? 5'h00 : 5'(CRS_OFF10_CYC - CRS_ON10_CYC);
		end else begin
			hold_d = (hold_q != 5'h00) ? hold_q - 5'h01 : 5'h00;
		end
		crs_tx = run & mode_i.half & (on | (hold_q != 5'h00));
		// Heartbeat: delay then a fixed pulse after the end of each 10M half duplex transmission.
		if (run && half10 && pipe_q[0].en && !mac_tx_i.en) begin
			hb_cnt_d = 7'(HB_DLY_CYC + HB_LEN_CYC);
		end else begin
			hb_cnt_d = (hb_cnt_q != 7'h00) ? hb_cnt_q - 7'h01 : 7'h00;
		end
		hb_col = (hb_cnt_q != 7'h00) && (hb_cnt_q <= 7'(HB_LEN_CYC));
		jab_d = jab_q;
		jab_cnt_d = '0;
		case (jab_q)
			JAB_IDLE: begin
				if (mac_tx_i.en && half10 && run) begin
					jab_cnt_d = jab_cnt_q + 24'h000001;
					if (jab_cnt_q == 24'(JAB_ON_CYC - 1)) begin
						jab_d = JAB_ACTIVE;
						jab_cnt_d = '0;
					end
				end
			end
			JAB_ACTIVE: begin
				jab_cnt_d = jab_cnt_q + 24'h000001;
				if (jab_cnt_q == 24'(JAB_OFF_CYC - 1)) begin
					jab_d = JAB_IDLE;
					jab_cnt_d = '0;
				end
			end
			default: jab_d = JAB_IDLE;
		endcase
	end

	// Transmit registers.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pipe_q <= '0;
			line_q <= '0;
			hold_q <= '0;
			hb_cnt_q <= '0;
			jab_q <= JAB_IDLE;
			jab_cnt_q <= '0;
		end else if (ce_i) begin
			pipe_q <= pipe_d;
			line_q <= line_d;
			hold_q <= hold_d;
			hb_cnt_q <= hb_cnt_d;
			jab_q <= jab_d;
			jab_cnt_q <= jab_cnt_d;
		end
	end

	// Receive: event delays, word hand-off and the combined carrier and collision.
	always_comb begin
		push = (s2_q[0] != ack_q) & open_q;
		ack_d = (push & buf_rdy) ? ~ack_q : ack_q;
		{on_d, off_d, gate_d} = {on_q, off_q, gate_q};
		{crs_rx_d, col_rx_d, col_pend_d, open_d} = {crs_rx_q, col_rx_q, col_pend_q, open_q};
		// Data toward the MAC is held back until the mode's receive latency has run.
		if (j_ev) begin
			open_d = 1'b0;
			gate_d = mode_i.stream ? 3'(RXJ_STR_CYC) : 3'(RXJ_MII_CYC);
		end else if (gate_q != 3'h0) begin
			gate_d = gate_q - 3'h1;
			open_d = (gate_q == 3'h1);
		end
		if (t_ev) begin
			off_d = 3'(RX_OFF_CYC);
		end else if (off_q != 3'h0) begin
			off_d = off_q - 3'h1;
			if (off_q == 3'h1) begin
				crs_rx_d = 1'b0;
				col_rx_d = 1'b0;
			end
		end
		// A new frame's carrier wins over the old frame's release in the same cycle.
		if (j_ev) begin
			on_d = 3'(CRS_RX_ON_CYC);
			col_pend_d = mode_i.half & mac_tx_i.en;
		end else if (on_q != 3'h0) begin
			on_d = on_q - 3'h1;
			if (on_q == 3'h1) begin
				crs_rx_d = 1'b1;
				col_rx_d = col_pend_q;
			end
		end
		if (!run) begin
			{crs_rx_d, col_rx_d, open_d} = '0;
		end
		crs_d = run & (crs_tx | crs_rx_d);
		col_d = run & mode_i.half & (col_rx_d | hb_col | (jab_q == JAB_ACTIVE));
	end

	// Receive registers.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{ack_q, crs_rx_q, col_rx_q, col_pend_q, open_q, crs_q, col_q} <= '0;
			{on_q, off_q, gate_q} <= '0;
		end else if (ce_i) begin
			{ack_q, crs_rx_q, col_rx_q, col_pend_q, open_q, crs_q, col_q} <=
				{ack_d, crs_rx_d, col_rx_d, col_pend_d, open_d, crs_d, col_d};
			{on_q, off_q, gate_q} <= {on_d, off_d, gate_d};
		end
	end

	// Two entries let the MAC stall for a word without the line losing one.
	pmlrt_buf #(.W(4), .DEPTH(2)) u_rx_buf (
		.clk_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.in_valid_i(push),
		.in_ready_o(buf_rdy),
		.in_data_i(l_word_q),
		.out_valid_o(buf_vld),
		.out_ready_i(mac_rx_ready_i),
		.out_data_o(buf_dat)
	);

	assign mac_rx_o = '{en: buf_vld, sym: buf_dat};
	assign crs_o = crs_q;
	assign col_o = col_q;
	assign tx_clk_ok_o = clk_ok_q;
	assign line_transmit_pair_o = line_q;
	assign line_rx_ready_o = l_rdy_q;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b_i || !ce_i);

	a_tx_mii_lat: assert property (run && mode_i.spd100 && !mode_i.stream && jab_q == JAB_IDLE
		&& mac_tx_i.en |=> line_transmit_pair_o.en) else $error("MII start late");
	a_tx_str_lat: assert property (run && mode_i.stream && jab_q == JAB_IDLE && mac_tx_i.en
		|-> ##2 line_transmit_pair_o.en) else $error("stream start late");
	a_crs_tx100: assert property (run && mode_i.half && mode_i.spd100 && $rose(mac_tx_i.en)
		|=> crs_o) else $error("100M carrier late");
	a_crs_tx10: assert property (run && half10 && $rose(mac_tx_i.en)
		|-> ##[1:8] crs_o) else $error("10M carrier late");
	a_crs_rx_on: assert property (run && j_ev && !t_ev |-> ##[1:6] crs_o)
		else $error("receive carrier late");
	a_col_rx_on: assert property (run && j_ev && mode_i.half && mac_tx_i.en
		|-> ##[1:6] col_o) else $error("collision late");
	a_hb_start: assert property (run && half10 && $fell(mac_tx_i.en) && jab_q == JAB_IDLE
		|-> ##[1:60] col_o) else $error("heartbeat missing");
	a_jab_quiet: assert property (jab_q == JAB_ACTIVE && run && mode_i.half
		|=> !line_transmit_pair_o.en && col_o) else $error("jabber not quiet");
	a_iso_quiet: assert property ($fell(hw_n) |-> ##[1:3] !tx_clk_ok_o)
		else $error("reset did not isolate");

	c_tx_frame: cover property (run && $rose(line_transmit_pair_o.en));
	c_rx_word: cover property (mac_rx_o.en && mac_rx_ready_i);
	c_collision: cover property (run && col_rx_q);
	c_heartbeat: cover property ($rose(hb_col));
	c_jabber: cover property ($rose(jab_q == JAB_ACTIVE));
endmodule : pmlrt_phy_timing

// *** design/pmlrt_pkg.sv ***
package pmlrt_pkg;

	// Clock period and line bit periods in nanoseconds.
	localparam int unsigned CLK_NS = 25;
	localparam int unsigned BIT100_NS = 10;
	localparam int unsigned BIT10_NS = 100;
	localparam int unsigned MS_NS = 1000000;

	// Converts a time to clock cycles, never less than one cycle.
	function automatic int unsigned ns_to_cyc(input int unsigned ns, input bit up);
		int unsigned c;
		c = up ? (ns + CLK_NS - 1) / CLK_NS : ns / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc

	// Latency limits in bit times.
	localparam int unsigned TXJ_MII_BITS = 3;
	localparam int unsigned TXJ_STR_BITS = 7;
	localparam int unsigned CRS_TX100_BITS = 4;
	localparam int unsigned CRS_ON10_BITS = 2;
	localparam int unsigned CRS_OFF10_BITS = 4;
	localparam int unsigned RXJ_MII_BITS = 17;
	localparam int unsigned RXJ_STR_BITS = 9;
	localparam int unsigned CRS_RX_ON_BITS = 14;
	localparam int unsigned COL_RX_ON_BITS = 13;
	localparam int unsigned RX_OFF_BITS = 18;

	// Heartbeat and isolation times in nanoseconds, long times in milliseconds.
	localparam int unsigned HB_DLY_NS = 850;
	localparam int unsigned HB_LEN_NS = 1000;
	localparam int unsigned ISO_NS = 60;
	localparam int unsigned JAB_ON_MS = 20;
	localparam int unsigned JAB_OFF_MS = 300;
	localparam int unsigned POR_MS = 45;
	localparam int unsigned HWR_MS = 35;

	// Longest latencies round down to whole cycles.
	localparam int unsigned TXJ_MII100_CYC = ns_to_cyc(TXJ_MII_BITS * BIT100_NS, 1'b0);
	localparam int unsigned TXJ_MII10_CYC = ns_to_cyc(TXJ_MII_BITS * BIT10_NS, 1'b0);
	localparam int unsigned TXJ_STR_CYC = ns_to_cyc(TXJ_STR_BITS * BIT100_NS, 1'b0);
	localparam int unsigned CRS_TX100_CYC = ns_to_cyc(CRS_TX100_BITS * BIT100_NS, 1'b0);
	localparam int unsigned CRS_ON10_CYC = ns_to_cyc(CRS_ON10_BITS * BIT10_NS, 1'b0);
	localparam int unsigned CRS_OFF10_CYC = ns_to_cyc(CRS_OFF10_BITS * BIT10_NS, 1'b0);
	localparam int unsigned RXJ_MII_CYC = ns_to_cyc(RXJ_MII_BITS * BIT100_NS, 1'b0);
	localparam int unsigned RXJ_STR_CYC = ns_to_cyc(RXJ_STR_BITS * BIT100_NS, 1'b0);
	localparam int unsigned CRS_RX_ON_CYC = ns_to_cyc(CRS_RX_ON_BITS * BIT100_NS, 1'b0);
	localparam int unsigned COL_RX_ON_CYC = ns_to_cyc(COL_RX_ON_BITS * BIT100_NS, 1'b0);
	localparam int unsigned RX_OFF_CYC = ns_to_cyc(RX_OFF_BITS * BIT100_NS, 1'b0);
	localparam int unsigned HB_DLY_CYC = ns_to_cyc(HB_DLY_NS, 1'b0);
	localparam int unsigned HB_LEN_CYC = ns_to_cyc(HB_LEN_NS, 1'b0);
	localparam int unsigned ISO_CYC = ns_to_cyc(ISO_NS, 1'b0);
	localparam int unsigned JAB_ON_CYC_DEF = JAB_ON_MS * (MS_NS / CLK_NS);
	localparam int unsigned JAB_OFF_CYC_DEF = JAB_OFF_MS * (MS_NS / CLK_NS);
	localparam int unsigned POR_CYC_DEF = POR_MS * (MS_NS / CLK_NS);
	localparam int unsigned HWR_CYC_DEF = HWR_MS * (MS_NS / CLK_NS);

	// Transmit delay line depth and values after reset.
	localparam int unsigned TX_PIPE = TXJ_MII10_CYC - 1;
	localparam logic [3:0] SYNC_RST = 4'h8;

	// Nibble with its qualifier, mode straps and one line receive sample.
	typedef struct packed {logic en; logic [3:0] sym;} pmlrt_sym_t;
	typedef struct packed {logic spd100; logic half; logic stream;} pmlrt_mode_t;
	typedef struct packed {logic j; logic t; logic valid; logic [3:0] sym;} pmlrt_line_rx_t;
	typedef enum {INIT_WAIT, INIT_RUN, INIT_ISO} pmlrt_init_t;
	typedef enum {JAB_IDLE, JAB_ACTIVE} pmlrt_jab_t;

endpackage : pmlrt_pkg

// *** sim/pmlrt_line_model.sv ***
`timescale 1ns/100ps
// Line side stand-in: sends a frame of four words on each request; after two opening cycles its clock runs only inside a frame.
module pmlrt_line_model
	import pmlrt_pkg::*;
(
	// Frame request and back-pressure from the block.
	input wire logic go_i,
	input wire logic ready_i,
	// Line side.
	output logic clk_line_o,
	output pmlrt_line_rx_t rx_o,
	output logic busy_o
);
	logic taken;
	int n;

	// One line clock cycle; the ready level is taken at the rising edge.
	task automatic tick;
		#24 clk_line_o = 1'b1;
		taken = ready_i;
		#24 clk_line_o = 1'b0;
	endtask : tick

	// Valid stays up across the words, each held until taken; idle data shows the inverse.
	initial begin
		clk_line_o = 1'b0;
		rx_o = '0;
		busy_o = 1'b0;
		repeat (2) tick();
		forever begin
			@(posedge go_i);
			busy_o = 1'b1;
			#7 tick();
			rx_o.j = 1'b1;
			tick();
			rx_o.j = 1'b0;
			rx_o.valid = 1'b1;
			for (int w = 0; w < 4; w++) begin
				rx_o.sym = 4'h3 + 4'(w * 5);
				n = 0;
				do begin
					tick();
					n++;
				end while (!taken && n < 500);
			end
			rx_o.valid = 1'b0;
			rx_o.sym = ~rx_o.sym;
			rx_o.t = 1'b1;
			tick();
			rx_o.t = 1'b0;
			repeat (4) tick();
			busy_o = 1'b0;
		end
	end
endmodule : pmlrt_line_model

// *** sim/tb_pmlrt_phy_timing.sv ***
`timescale 1ns/100ps
// Self-checking bench; long counts are shortened through the parameters.
module tb_pmlrt_phy_timing;
	import pmlrt_pkg::*;
	localparam int unsigned JON = 50;
	localparam int unsigned JOFF = 100;
	localparam int unsigned PORC = 20;
	localparam int unsigned HWRC = 20;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic ce_i = 1'b1;
	logic hwr_low = 1'b1;
	logic mrdy = 1'b0;
	logic go = 1'b0;
	pmlrt_mode_t mode = '{1'b1, 1'b1, 1'b0};
	pmlrt_sym_t mtx = '0;
	pmlrt_sym_t mrx, ltx;
	pmlrt_line_rx_t lrx;
	logic clk_line, crs, col, ok, lrdy, busy;
	int fail_count = 0;
	int check_count = 0;

	// System clock at 40 MHz.
	always #12.5 clk_sys_i = ~clk_sys_i;

	// Block and line stand-in.
	pmlrt_phy_timing #(.JAB_ON_CYC(JON), .JAB_OFF_CYC(JOFF), .POR_CYC(PORC), .HWR_CYC(HWRC)) dut_u (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .clk_line_i(clk_line),
		.mode_i(mode), .hw_reset_low_in_i(hwr_low), .mac_tx_i(mtx), .mac_rx_o(mrx),
		.mac_rx_ready_i(mrdy), .crs_o(crs), .col_o(col), .tx_clk_ok_o(ok),
		.line_transmit_pair_o(ltx), .line_receive_pair_i(lrx), .line_rx_ready_o(lrdy));
	pmlrt_line_model line_u (.go_i(go), .ready_i(lrdy), .clk_line_o(clk_line), .rx_o(lrx),
		.busy_o(busy));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : cyc

	// Bounded wait for the clock-valid flag; running out ends the run.
	task automatic wait_ok(input logic v, input int lim, output int n);
		n = 0;
		while (ok !== v) begin
			cyc(1);
			n++;
			if (n > lim) begin
				fail_count++;
				$display("[ERR] tx_clk_ok_o expected %0h seen timeout", v);
				tally_and_finish();
			end
		end
	endtask : wait_ok

	// Power-on count, then the reset pin isolating and restarting the block.
	task automatic t_reset;
		int n;
		chk("rx ready in reset", lrdy, 1'b1);
		chk("clock ok in reset", ok, 1'b0);
		rst_b_i = 1'b1;
		wait_ok(1'b1, PORC + 10, n);
		chk("power-on length", n >= PORC - 1 && n <= PORC + 3, 1'b1);
		hwr_low = 1'b0;
		wait_ok(1'b0, 10, n);
		chk("isolation delay", n <= 6, 1'b1);
		cyc(3);
		hwr_low = 1'b1;
		wait_ok(1'b1, HWRC + 10, n);
		chk("pin release length", n >= HWRC && n <= HWRC + 4, 1'b1);
	endtask : t_reset

	// One transmit burst: start latency, carrier on and off, heartbeat in 10M half duplex.
	task automatic t_tx(input pmlrt_mode_t m, input int lat, input int on_lim, input int off_lim);
		int a, c, f, h, w;
		mode = m;
		cyc(4);
		mtx = '{en: 1'b1, sym: 4'hA};
		a = 99;
		c = 99;
		for (int k = 1; k <= 40; k++) begin
			cyc(1);
			if (a == 99 && ltx.en === 1'b1) begin
				a = k;
				chk("tx symbol", ltx.sym, 4'hA);
			end
			if (c == 99 && crs === 1'b1) c = k;
		end
		chk("tx start", a <= lat, 1'b1);
		if (m.half) chk("crs on", c <= on_lim, 1'b1);
		mtx.en = 1'b0;
		f = 99;
		h = 99;
		w = 0;
		for (int k = 1; k <= 120; k++) begin
			cyc(1);
			if (f == 99 && crs === 1'b0) f = k;
			if (col === 1'b1) begin
				if (h == 99) h = k;
				w++;
			end
		end
		if (m.half) chk("crs off", f <= off_lim, 1'b1);
		if (m.half && !m.spd100) begin
			chk("heartbeat delay", h <= 1500 / CLK_NS, 1'b1);
			chk("heartbeat width", w >= 1 && w <= 1500 / CLK_NS, 1'b1);
		end else
			chk("no heartbeat", w, 0);
	endtask : t_tx

	// Endless transmit in 10M half duplex: line silenced and collision held, then released.
	task automatic t_jab;
		int n;
		mode = '{1'b0, 1'b1, 1'b0};
		cyc(4);
		mtx = '{en: 1'b1, sym: 4'h5};
		cyc(JON - 5);
		chk("line before jabber", ltx.en, 1'b1);
		cyc(25);
		chk("line in jabber", ltx.en, 1'b0);
		chk("col in jabber", col, 1'b1);
		mtx.en = 1'b0;
		n = 0;
		while (col === 1'b1 && n < JOFF + 60) begin
			cyc(1);
			n++;
		end
		chk("jabber release", n >= JOFF - 30 && n < JOFF + 60, 1'b1);
		cyc(150);
	endtask : t_jab

	// One 100M half duplex frame received, MII or stream; idle transmit means a stalling MAC.
	task automatic t_rx(input logic tx, input logic st);
		int jc, tc, cr, cf, fe, k, lim;
		mode = '{1'b1, 1'b1, st};
		mtx = '{en: tx, sym: 4'h0};
		{jc, tc, cr, cf, fe, k} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1, -32'sd1, 32'sd0};
		cyc(4);
		go = 1'b1;
		for (int n = 0; n < 700; n++) begin
			cyc(1);
			go = 1'b0;
			mrdy = tx || n >= 80;
			if (n == 40) mtx.en = 1'b0;
			if (jc < 0 && lrx.j === 1'b1) jc = n;
			if (tc < 0 && lrx.t === 1'b1) tc = n;
			if (jc >= 0 && cr < 0 && (tx ? col : crs) === 1'b1) cr = n;
			if (tc >= 0 && cf < 0 && (tx ? col : crs) === 1'b0) cf = n;
			if (fe < 0 && mrx.en === 1'b1) fe = n;
			if (mrdy && mrx.en === 1'b1) begin
				chk("rx word", mrx.sym, 4'(4'h3 + 4'(k * 5)));
				k++;
			end
		end
		chk("rx word count", k, 4);
		chk("line frame done", busy, 1'b0);
		lim = (st ? 9 : 17) * BIT100_NS / CLK_NS + 5;
		if (tx) chk("rx data latency", fe - jc <= lim, 1'b1);
		chk("carrier or col on", cr - jc >= (tx ? 9 : 10) * BIT100_NS / CLK_NS &&
			cr - jc <= (tx ? 13 : 14) * BIT100_NS / CLK_NS + 4, 1'b1);
		chk("carrier or col off", cf - tc >= 13 * BIT100_NS / CLK_NS &&
			cf - tc <= 18 * BIT100_NS / CLK_NS + 4, 1'b1);
		cyc(20);
	endtask : t_rx

	// Main sequence; reset is held three cycles before the first scenario releases it.
	initial begin
		cyc(3);
		t_reset();
		t_tx('{1'b1, 1'b1, 1'b0}, 3 * BIT100_NS / CLK_NS, 1, 1);
		t_tx('{1'b1, 1'b1, 1'b1}, 7 * BIT100_NS / CLK_NS, 1, 1);
		t_tx('{1'b0, 1'b1, 1'b0}, 3 * BIT10_NS / CLK_NS, 2 * BIT10_NS / CLK_NS,
			4 * BIT10_NS / CLK_NS);
		t_tx('{1'b1, 1'b0, 1'b0}, 3 * BIT100_NS / CLK_NS, 1, 1);
		t_jab();
		t_rx(1'b0, 1'b0);
		t_rx(1'b1, 1'b0);
		t_rx(1'b1, 1'b1);
		tally_and_finish();
	end
endmodule : tb_pmlrt_phy_timing
